// >>> verilog/lsd_seq.sv
// Startup sequencer of a four-channel LED sink driver: wake, checks, sink detect, soft-start.
// Assumes analog comparator results arrive as synchronous levels on ref_clk_i.
// Summary of operation
// - Wake only when enable is high and input supply is above lockout.
// - Boost and sinks stay off until dimming input goes high.
// - Check output short, sink shorts, program pins; switch only if all pass.
// - Enable and dimming may be one wire; it means power and dimming.
// - Shut off after enable low longer than 16 ms; shorter pulses ignored.
// - Detection starts when dimming high and gate pulled 3.3 V below supply.
// - After all sink pins rise above 120 mV, wait 1.5 ms then decide.
// - Below 120 mV short fault, middle unused, above 340 mV in use.
// - Unused channels disabled and dropped from boost regulation loop.
// - Sink short pulls fault low and detection keeps retrying.
// - When the short clears, continue into soft-start automatically.
// - Program pin shorts handled like sink shorts: fault, retry, resume.
// - Fault output released when sink detection phase ends.
// - Sync clock output runs once internal supply is up and the sequencer has left idle.
// - Soft-start ends on regulation, 93% overvoltage level, or ramp timer.
// - Latched fault clears when enable high and dimming low over 16 ms.
`include "lsd_cfg.svh"
module lsd_seq
   import lsd_pkg::*;
(
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   enable_i,
   input  wire logic                   dimming_i,
   input  wire logic                   supply_ok_i,
   input  wire logic                   vdd_ready_i,
   input  wire logic                   gate_pulled_i,
   input  wire logic                   out_short_i,
   input  wire logic                   freq_pin_fault_i,
   input  wire logic                   cur_pin_fault_i,
   input  wire lsd_sink_lvl_t [3:0]    sink_lvl_i,
   input  wire logic                   all_in_reg_i,
   input  wire logic                   out_at_93pct_i,
   input  wire logic                   latch_fault_i,
   output logic                        gate_drive_o,
   output logic                        boost_en_o,
   output logic                        soft_start_o,
   output logic [3:0]                  sink_en_o,
   output logic                        fault_n_oe_o,
   output logic                        sync_clock_output_o,
   output lsd_state_t                  state_o
);
   lsd_state_all_t s_q;
   lsd_state_all_t s_d;

   function automatic logic [`LSD_CNT_W-1:0] sat_inc(input logic [`LSD_CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction : sat_inc

   logic                 shutdown;
   logic                 pin_short;
   logic                 prog_short;
   logic [`LSD_CNT_W-1:0] n_enoff;
   logic [`LSD_CNT_W-1:0] n_clr;
   logic [`LSD_CNT_W-1:0] n_det;
   logic [`LSD_CNT_W-1:0] n_ss;

   assign n_enoff = `LSD_CNT_W'(`LSD_N_ENOFF);
   assign n_clr   = `LSD_CNT_W'(`LSD_N_CLR);
   assign n_det   = `LSD_CNT_W'(`LSD_N_DET);
   assign n_ss    = `LSD_CNT_W'(`LSD_N_SS);

   always_comb begin
      pin_short  = 1'b0;
      for (int i = 0; i < `LSD_NCH; i++) begin
         pin_short = pin_short | ~sink_lvl_i[i].above_low;
      end
      prog_short = freq_pin_fault_i | cur_pin_fault_i;
      shutdown   = (s_q.en_low_cnt > n_enoff) || !supply_ok_i;
   end

   always_comb begin
      s_d = s_q;
      // Single-wire use: enable low counts toward shutdown, but short lows only dim
      s_d.en_low_cnt  = enable_i ? '0 : sat_inc(s_q.en_low_cnt);
      s_d.pwm_low_cnt = (enable_i && !dimming_i) ? sat_inc(s_q.pwm_low_cnt) : '0;
      // Sync clock divider runs whenever internal supply is up, in any state except idle
      if (vdd_ready_i && s_q.st != LSD_IDLE) begin
         if (s_q.div == 3'(`LSD_SYNC_CLOCK_OUTPUT_DIV - 1)) begin
            s_d.div     = '0;
            s_d.clk_out = ~s_q.clk_out;
         end else begin
            s_d.div = s_q.div + 3'h1;
         end
      end else begin
         s_d.div     = '0;
         s_d.clk_out = 1'b0;
      end
      case (s_q.st)
         LSD_IDLE: begin
            s_d.tmr     = '0;
            s_d.ch_used = '0;
            s_d.fault   = 1'b0;
            if (enable_i && supply_ok_i) begin
               s_d.st = LSD_GATE;
            end
         end
         LSD_GATE: begin
            if (gate_pulled_i) begin
               s_d.st = LSD_WAITPW;
            end
         end
         LSD_WAITPW: begin
            if (out_short_i) begin
               s_d.st = LSD_LATCH;
            end else if (dimming_i && gate_pulled_i) begin
               s_d.st  = LSD_DETECT;
               s_d.tmr = '0;
            end
         end
         LSD_DETECT: begin
            if (out_short_i) begin
               s_d.st = LSD_LATCH;
            end else if (pin_short || prog_short) begin
               s_d.fault = 1'b1;
               s_d.tmr   = '0;
            end else if (s_q.tmr >= n_det - 1'b1) begin
               for (int i = 0; i < `LSD_NCH; i++) begin
                  s_d.ch_used[i] = sink_lvl_i[i].above_high;
               end
               s_d.fault = 1'b0;
               s_d.tmr   = '0;
               s_d.st    = LSD_SOFT;
            end else begin
               s_d.tmr = s_q.tmr + 1'b1;
            end
         end
         LSD_SOFT: begin
            s_d.tmr = sat_inc(s_q.tmr);
            if (prog_short) begin
               s_d.fault = 1'b1;
            end else if (all_in_reg_i || out_at_93pct_i || s_q.tmr >= n_ss - 1'b1) begin
               s_d.st = LSD_RUN;
            end
         end
         LSD_RUN: begin
            s_d.fault = prog_short;
            if (latch_fault_i) begin
               s_d.st = LSD_LATCH;
            end
         end
         LSD_LATCH: begin
            s_d.fault = 1'b1;
            if (s_q.pwm_low_cnt > n_clr) begin
               s_d.fault = 1'b0;
               s_d.st    = LSD_WAITPW;
            end
         end
         default: begin
            s_d.st = LSD_IDLE;
         end
      endcase
      // Clock output keeps running through a latch clear; only shutdown or loss of internal supply stops it
      if (shutdown) begin
         s_d.st      = LSD_IDLE;
         s_d.tmr     = '0;
         s_d.ch_used = '0;
         s_d.fault   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_q <= '{st: LSD_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Sinks follow dimming only while boost is on in soft-start or run; dimming is host brightness
   always_comb begin
      gate_drive_o        = (s_q.st != LSD_IDLE);
      soft_start_o        = (s_q.st == LSD_SOFT);
      boost_en_o          = (s_q.st == LSD_SOFT || s_q.st == LSD_RUN) && !prog_short;
      sink_en_o           = (boost_en_o && dimming_i) ? s_q.ch_used : 4'h0;
      fault_n_oe_o        = ~s_q.fault;
      sync_clock_output_o = s_q.clk_out;
      state_o             = s_q.st;
   end
endmodule : lsd_seq

// >>> verilog/lsd_cfg.svh
// Timing and field constants for the LED driver startup sequencer.
// Assumes a 10 MHz reference clock; included by the package and the design.
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH
`define LSD_CLK_HZ          10000000
`define LSD_T_ENOFF_US      16000
`define LSD_T_CLR_US        16000
`define LSD_T_DET_US        1500
`define LSD_T_SS_US         16400
`define LSD_N_ENOFF         ((`LSD_T_ENOFF_US * (`LSD_CLK_HZ / 1000000)))
`define LSD_N_CLR           ((`LSD_T_CLR_US * (`LSD_CLK_HZ / 1000000)))
`define LSD_N_DET           ((`LSD_T_DET_US * (`LSD_CLK_HZ / 1000000)))
`define LSD_N_SS            ((`LSD_T_SS_US * (`LSD_CLK_HZ / 1000000)))
`define LSD_CNT_W           18
`define LSD_NCH             4
`define LSD_SYNC_CLOCK_OUTPUT_DIV      5
`endif

// >>> verilog/lsd_pkg.sv
// Types for the LED driver startup sequencer.
// Assumes lsd_cfg.svh sits on the include path.
`include "lsd_cfg.svh"
package lsd_pkg;
   typedef enum logic [6:0] {
      LSD_IDLE   = 7'h01,
      LSD_GATE   = 7'h02,
      LSD_WAITPW = 7'h04,
      LSD_DETECT = 7'h08,
      LSD_SOFT   = 7'h10,
      LSD_RUN    = 7'h20,
      LSD_LATCH  = 7'h40
   } lsd_state_t;
   // Comparator levels of one sink pin from the analog front end
   typedef struct packed {
      logic above_low;   // > 120 mV
      logic above_high;  // > 340 mV
   } lsd_sink_lvl_t;
   typedef struct packed {
      lsd_state_t                 st;
      logic [`LSD_CNT_W-1:0]      en_low_cnt;
      logic [`LSD_CNT_W-1:0]      pwm_low_cnt;
      logic [`LSD_CNT_W-1:0]      tmr;
      logic [`LSD_NCH-1:0]        ch_used;
      logic                       fault;
      logic [2:0]                 div;
      logic                       clk_out;
   } lsd_state_all_t;
endpackage : lsd_pkg

// >>> test/lsd_host.sv
// Host model driving the enable and dimming pins.
// Assumes callers invoke its tasks just after a rising edge.
module lsd_host #(
   parameter bit TIED = 1'b0
) (
   output logic enable_o,
   output logic dimming_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pwm_lvl = 1'b0;
   initial enable_o = 1'b0;
   assign dimming_o = TIED ? enable_o : pwm_lvl;
   task automatic power(input logic on);
      enable_o = on;
   endtask : power
   // Brightness changes only make sense with enable held high
   task automatic dim(input logic lvl);
      pwm_lvl = lvl;
   endtask : dim
endmodule : lsd_host

// >>> test/lsd_seq_checker.sv
// Port-level assertions for the startup sequencer.
// Assumes lsd_pkg is compiled; bound into every lsd_seq.
module lsd_seq_checker
   import lsd_pkg::*;
(
   input wire logic                ref_clk_i,
   input wire logic                rst_i,
   input wire logic                enable_i,
   input wire logic                dimming_i,
   input wire logic                supply_ok_i,
   input wire logic                gate_pulled_i,
   input wire logic                out_short_i,
   input wire logic                freq_pin_fault_i,
   input wire logic                cur_pin_fault_i,
   input wire lsd_sink_lvl_t [3:0] sink_lvl_i,
   input wire logic                all_in_reg_i,
   input wire logic                out_at_93pct_i,
   input wire logic                latch_fault_i,
   input wire logic                boost_en_o,
   input wire logic [3:0]          sink_en_o,
   input wire logic                fault_n_oe_o,
   input wire lsd_state_t          state_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire logic on_w = enable_i && supply_ok_i;
   wire logic prog_w = !freq_pin_fault_i && !cur_pin_fault_i;
   // Low-threshold bits sit at the odd positions of the packed levels
   wire logic short_w = (sink_lvl_i & 8'haa) != 8'haa;
   AST_WAKE_ON: assert property (state_o == LSD_IDLE && on_w |=> state_o == LSD_GATE)
      else $error("no wake");
   AST_WAKE_OFF: assert property (state_o == LSD_IDLE && !on_w |=> state_o == LSD_IDLE)
      else $error("woke early");
   AST_PRE_OFF: assert property (state_o inside {LSD_IDLE, LSD_GATE, LSD_WAITPW, LSD_DETECT} |-> !boost_en_o)
      else $error("boost early");
   AST_SINK_GATE: assert property ((sink_en_o & ~{4{dimming_i && boost_en_o}}) == 4'h0)
      else $error("sink on without dimming");
   AST_DET_GO: assert property (state_o == LSD_WAITPW && on_w && dimming_i && gate_pulled_i && !out_short_i && prog_w
      |=> state_o == LSD_DETECT)
      else $error("no detect");
   AST_SHORT_FLT: assert property (state_o == LSD_DETECT && on_w && dimming_i && gate_pulled_i && !out_short_i
      && short_w |=> !fault_n_oe_o && state_o == LSD_DETECT)
      else $error("short not flagged");
   AST_FLT_REL: assert property (state_o == LSD_SOFT && $past(state_o) == LSD_DETECT && $past(prog_w) |-> fault_n_oe_o)
      else $error("fault held");
   AST_SS_END: assert property (state_o == LSD_SOFT && on_w && prog_w && !latch_fault_i
      && (all_in_reg_i || out_at_93pct_i) |=> state_o == LSD_RUN)
      else $error("soft-start stuck");
   AST_SHUT: assert property (state_o != LSD_IDLE && !supply_ok_i |=> state_o == LSD_IDLE)
      else $error("no shutdown");
   cover property (state_o == LSD_DETECT && !fault_n_oe_o);
   cover property (state_o == LSD_SOFT);
   cover property (state_o == LSD_RUN && sink_en_o != 4'h0);
endmodule : lsd_seq_checker
bind lsd_seq lsd_seq_checker u_chk (.ref_clk_i, .rst_i, .enable_i, .dimming_i, .supply_ok_i, .gate_pulled_i,
   .out_short_i, .freq_pin_fault_i, .cur_pin_fault_i, .sink_lvl_i, .all_in_reg_i, .out_at_93pct_i,
   .latch_fault_i, .boost_en_o, .sink_en_o, .fault_n_oe_o, .state_o);

// >>> test/tb.sv
// Self-checking bench for lsd_seq: wake, detection faults, soft-start, dimming, shutdown.
// Assumes lsd_host drives enable and dimming; the checker binds itself.
module tb
   import lsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic dim; logic [3:0] en;} lsd_row_t;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, supply_ok_i = 1'b0, gate_pulled_i = 1'b0;
   logic cur_pin_fault_i = 1'b0, all_in_reg_i = 1'b0;
   logic vdd_ready_i = 1'b1, out_short_i = 1'b0, freq_pin_fault_i = 1'b0;
   logic out_at_93pct_i = 1'b0, latch_fault_i = 1'b0;
   logic clk_seen;
   wire logic gate_drive_o, soft_start_o, sync_clock_output_o;
   lsd_sink_lvl_t [3:0] sink_lvl_i = 8'hff;
   wire logic enable_i, dimming_i, boost_en_o, fault_n_oe_o;
   wire logic [3:0] sink_en_o;
   lsd_state_t state_o;
   int err_total = 0, samples_checked = 0;
   // Channel 1 is unused, so it never lights
   lsd_row_t rows [3] = '{'{1'b1, 4'hd}, '{1'b0, 4'h0}, '{1'b1, 4'hd}};
   always #50 ref_clk_i = ~ref_clk_i;
   lsd_host u_host (.enable_o(enable_i), .dimming_o(dimming_i));
   lsd_seq u_dut (.ref_clk_i, .rst_i, .enable_i, .dimming_i, .supply_ok_i, .vdd_ready_i, .gate_pulled_i,
      .out_short_i, .freq_pin_fault_i, .cur_pin_fault_i, .sink_lvl_i, .all_in_reg_i,
      .out_at_93pct_i, .latch_fault_i, .gate_drive_o, .boost_en_o, .soft_start_o, .sink_en_o,
      .fault_n_oe_o, .sync_clock_output_o, .state_o);
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : step
   task automatic chk_st(input lsd_state_t got, input lsd_state_t exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t state %h not %h", $time, got, exp);
      end
   endtask : chk_st
   task automatic chk_v(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t output %h not %h", $time, got, exp);
      end
   endtask : chk_v
   task automatic print_verdict;
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #(40000 * 100);
      err_total++;
      print_verdict();
   end
   initial begin
      step(5);
      rst_i = 1'b0;
      step(1);
      chk_st(state_o, LSD_IDLE);
      chk_v({3'h0, fault_n_oe_o}, 4'h1);
      chk_v({gate_drive_o, sync_clock_output_o, 2'h0}, 4'h0);
      u_host.power(1'b1);
      step(5);
      chk_st(state_o, LSD_IDLE);
      supply_ok_i = 1'b1;
      step(2);
      chk_st(state_o, LSD_GATE);
      chk_v({3'h0, gate_drive_o}, 4'h1);
      gate_pulled_i = 1'b1;
      step(20);
      chk_st(state_o, LSD_WAITPW);
      chk_v({3'h0, boost_en_o}, 4'h0);
      sink_lvl_i = 8'hf8;
      u_host.dim(1'b1);
      step(3);
      chk_st(state_o, LSD_DETECT);
      chk_v({3'h0, fault_n_oe_o}, 4'h0);
      step(15100);
      chk_st(state_o, LSD_DETECT);
      sink_lvl_i = 8'hfb;
      step(14990);
      chk_st(state_o, LSD_DETECT);
      step(20);
      chk_st(state_o, LSD_SOFT);
      chk_v({3'h0, fault_n_oe_o}, 4'h1);
      chk_v({3'h0, soft_start_o}, 4'h1);
      all_in_reg_i = 1'b1;
      step(2);
      chk_st(state_o, LSD_RUN);
      chk_v({3'h0, soft_start_o}, 4'h0);
      // Divider toggles every 5 clocks, so samples 5 apart must differ
      clk_seen = sync_clock_output_o;
      step(5);
      chk_v({3'h0, sync_clock_output_o}, {3'h0, ~clk_seen});
      foreach (rows[i]) begin
         u_host.dim(rows[i].dim);
         step(1);
         chk_v(sink_en_o, rows[i].en);
      end
      cur_pin_fault_i = 1'b1;
      step(3);
      chk_v({fault_n_oe_o, boost_en_o, 2'h0}, 4'h0);
      cur_pin_fault_i = 1'b0;
      step(3);
      chk_v({fault_n_oe_o, boost_en_o, 2'h0}, 4'hc);
      freq_pin_fault_i = 1'b1;
      step(3);
      chk_v({fault_n_oe_o, boost_en_o, 2'h0}, 4'h0);
      freq_pin_fault_i = 1'b0;
      step(3);
      chk_v({fault_n_oe_o, boost_en_o, 2'h0}, 4'hc);
      vdd_ready_i = 1'b0;
      step(2);
      chk_v({3'h0, sync_clock_output_o}, 4'h0);
      vdd_ready_i = 1'b1;
      u_host.power(1'b0);
      step(100);
      u_host.power(1'b1);
      step(2);
      chk_st(state_o, LSD_RUN);
      latch_fault_i = 1'b1;
      step(2);
      chk_st(state_o, LSD_LATCH);
      chk_v({3'h0, fault_n_oe_o}, 4'h0);
      latch_fault_i = 1'b0;
      supply_ok_i = 1'b0;
      step(2);
      chk_st(state_o, LSD_IDLE);
      chk_v(sink_en_o, 4'h0);
      print_verdict();
   end
endmodule : tb
